/* hw/qgpio_top.sv */
`include "qgpio_cfg.svh"

// Function
// - Four ports, 30 pins, each with software direction, pull-up and open-drain.
// - An output pin drives the value written to its data register bit.
// - Reading the data register bit of an input pin returns the pin level.
// - Direction bit 0 is input and 1 is output; all clear on reset.
// - Pull-up bit 1 connects the pull-up, 0 disconnects; all clear on reset.
// - Open-drain bit selects open-drain or push-pull; push-pull after reset except port 0 pin 2.
// - All registers reset to 00H except port 0 open-drain, which resets to 04H.
// - Each pin has a debounce enable bit filtering its input by 1, 2, 4 or 8 us.
// - One shared field selects the debounce length for all enabled pins.
// - Port debounce codes 0..3 mean 1/2/4/8 us; reset debounce codes 8/16/32/64 us.
// - A high-current register has one bit per port 3 pin selecting high-current mode while that pin is an output.
// - Each high-current bit serves a port 3 pin: 0 is 40 mA sink, 1 is 160 mA.
// - Two digital input select registers hold one bit per analog-capable pin.
// - A clear bit keeps digital input; a set bit gives the pin to analog input.
module qgpio_top
  import qgpio_pkg::*;
#(
  parameter int PORTS = 4,
  parameter int CW = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Special function register access
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // Pins, port n in bits 8n+7..8n
  input wire logic [31:0] pin_i,
  output logic [31:0] pin_o,
  output logic [31:0] pin_oe_o,
  output logic [31:0] pin_pullup_o,
  // Analog, drive strength and reset debounce controls
  output logic [7:0] high_current_o,
  output logic [14:0] analog_select_o,
  output logic [1:0] reset_debounce_sel_o,
  output logic [CW-1:0] reset_debounce_cycles_o
);
  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  qgpio_byte_t data_reg [PORTS];
  qgpio_byte_t dir_reg [PORTS];
  qgpio_byte_t pu_reg [PORTS];
  qgpio_byte_t od_reg [PORTS];
  qgpio_byte_t db_reg [PORTS];
  qgpio_byte_t debounce_time_select;
  qgpio_byte_t high_current_select;
  qgpio_byte_t digital_input_select_a;
  qgpio_byte_t digital_input_select_b;
  logic [31:0] pin_filtered;
  logic [31:0] pin_digital;
  logic [CW-1:0] dbt_cycles;

  // Decode: kind 0 data, 1 direction, 2 pull-up, 3 open-drain, 4 debounce,
  // 5 global, 7 unmapped. Index is the port or the global register number.
  function automatic logic [4:0] decode(input logic [7:0] a);
    case (a)
      `QGPIO_PORT0_DATA: decode = {3'd0, 2'd0};
      `QGPIO_PORT1_DATA: decode = {3'd0, 2'd1};
      `QGPIO_PORT2_DATA: decode = {3'd0, 2'd2};
      `QGPIO_PORT3_DATA: decode = {3'd0, 2'd3};
      `QGPIO_PORT0_DIRECTION: decode = {3'd1, 2'd0};
      `QGPIO_PORT1_DIRECTION: decode = {3'd1, 2'd1};
      `QGPIO_PORT2_DIRECTION: decode = {3'd1, 2'd2};
      `QGPIO_PORT3_DIRECTION: decode = {3'd1, 2'd3};
      `QGPIO_PORT0_PULLUP: decode = {3'd2, 2'd0};
      `QGPIO_PORT1_PULLUP: decode = {3'd2, 2'd1};
      `QGPIO_PORT2_PULLUP: decode = {3'd2, 2'd2};
      `QGPIO_PORT3_PULLUP: decode = {3'd2, 2'd3};
      `QGPIO_PORT0_OPENDRAIN: decode = {3'd3, 2'd0};
      `QGPIO_PORT1_OPENDRAIN: decode = {3'd3, 2'd1};
      `QGPIO_PORT2_OPENDRAIN: decode = {3'd3, 2'd2};
      `QGPIO_PORT3_OPENDRAIN: decode = {3'd3, 2'd3};
      `QGPIO_PORT0_DEBOUNCE: decode = {3'd4, 2'd0};
      `QGPIO_PORT1_DEBOUNCE: decode = {3'd4, 2'd1};
      `QGPIO_PORT2_DEBOUNCE: decode = {3'd4, 2'd2};
      `QGPIO_PORT3_DEBOUNCE: decode = {3'd4, 2'd3};
      `QGPIO_DEBOUNCE_TIME_SELECT: decode = {3'd5, 2'd0};
      `QGPIO_HIGH_CURRENT_SELECT: decode = {3'd5, 2'd1};
      `QGPIO_DIGITAL_INPUT_SELECT_A: decode = {3'd5, 2'd2};
      `QGPIO_DIGITAL_INPUT_SELECT_B: decode = {3'd5, 2'd3};
      default: decode = {3'd7, 2'd0};
    endcase
  endfunction

  // Port 2 has only six pins; its upper bits are not stored and read as zero.
  function automatic qgpio_byte_t port_mask(input int p);
    port_mask = (p == 2) ? `QGPIO_PORT2_MASK : 8'hFF;
  endfunction

  logic [4:0] dec;
  logic [2:0] kind;
  logic [1:0] idx;
  assign dec = decode(sfr_addr_i);
  assign kind = dec[4:2];
  assign idx = dec[1:0];

  // --------------------------------------------------------------------------
  // Per-port registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < PORTS; p++) begin
        data_reg[p] <= `QGPIO_RESET_VALUE;
        dir_reg[p] <= `QGPIO_RESET_VALUE;
        pu_reg[p] <= `QGPIO_RESET_VALUE;
        od_reg[p] <= (p == 0) ? `QGPIO_PORT0_OD_RESET : `QGPIO_RESET_VALUE;
        db_reg[p] <= `QGPIO_RESET_VALUE;
      end
    end else if (sfr_wr_i) begin
      for (int p = 0; p < PORTS; p++) begin
        if (idx == 2'(p)) begin
          case (kind)
            3'd0: data_reg[p] <= sfr_wdata_i & port_mask(p);
            3'd1: dir_reg[p] <= sfr_wdata_i & port_mask(p);
            3'd2: pu_reg[p] <= sfr_wdata_i & port_mask(p);
            3'd3: od_reg[p] <= sfr_wdata_i & port_mask(p);
            3'd4: db_reg[p] <= sfr_wdata_i & port_mask(p);
            default: ;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Shared selection registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      debounce_time_select <= `QGPIO_RESET_VALUE;
      high_current_select <= `QGPIO_RESET_VALUE;
      digital_input_select_a <= `QGPIO_RESET_VALUE;
      digital_input_select_b <= `QGPIO_RESET_VALUE;
    end else if (sfr_wr_i && kind == 3'd5) begin
      case (idx)
        2'd0: debounce_time_select <= sfr_wdata_i & `QGPIO_DBT_USED_MASK;
        2'd1: high_current_select <= sfr_wdata_i;
        2'd2: digital_input_select_a <= sfr_wdata_i;
        default: digital_input_select_b <= sfr_wdata_i & `QGPIO_DIGSEL_B_MASK;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Debounce length
  // --------------------------------------------------------------------------
  function automatic logic [CW-1:0] port_cycles(input logic [1:0] code);
    case (code)
      2'd0: port_cycles = CW'(`QGPIO_DBT_CYC_1);
      2'd1: port_cycles = CW'(`QGPIO_DBT_CYC_2);
      2'd2: port_cycles = CW'(`QGPIO_DBT_CYC_4);
      default: port_cycles = CW'(`QGPIO_DBT_CYC_8);
    endcase
  endfunction

  function automatic logic [CW-1:0] reset_cycles(input logic [1:0] code);
    case (code)
      2'd0: reset_cycles = CW'(`QGPIO_RST_CYC_8);
      2'd1: reset_cycles = CW'(`QGPIO_RST_CYC_16);
      2'd2: reset_cycles = CW'(`QGPIO_RST_CYC_32);
      default: reset_cycles = CW'(`QGPIO_RST_CYC_64);
    endcase
  endfunction

  // The reset pin filter itself lives with the reset logic; only its length
  // is chosen here.
  assign dbt_cycles = port_cycles(debounce_time_select[`QGPIO_PORT_DBT_LSB +: 2]);
  assign reset_debounce_sel_o = debounce_time_select[`QGPIO_RESET_DBT_LSB +: 2];
  assign reset_debounce_cycles_o = reset_cycles(reset_debounce_sel_o);

  // --------------------------------------------------------------------------
  // Input path
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_pin
      qgpio_debounce #(
        .CW(CW)
      ) u_db (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(db_reg[g / 8][g % 8]),
        .limit_i(dbt_cycles),
        .raw_i(pin_i[g]),
        .level_o(pin_filtered[g])
      );
    end
  endgenerate

  // Analog-capable pins: port 0 bits 0,1,3..7, port 1 bits 0,3..7, port 2 bits 0,1.
  assign analog_select_o = {digital_input_select_b[6:0], digital_input_select_a};

  always_comb begin
    pin_digital = pin_filtered;
    // An analog-assigned pin reads as zero; its digital buffer is off.
    if (analog_select_o[0]) pin_digital[0] = 1'b0;
    if (analog_select_o[1]) pin_digital[1] = 1'b0;
    for (int k = 2; k < 7; k++) begin
      if (analog_select_o[k]) pin_digital[k + 1] = 1'b0;
    end
    if (analog_select_o[7]) pin_digital[8] = 1'b0;
    for (int k = 8; k < 13; k++) begin
      if (analog_select_o[k]) pin_digital[k + 3] = 1'b0;
    end
    if (analog_select_o[13]) pin_digital[16] = 1'b0;
    if (analog_select_o[14]) pin_digital[17] = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
      pin_pullup_o <= '0;
      high_current_o <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        for (int b = 0; b < 8; b++) begin
          // Open-drain drives low only and releases on a high value.
          pin_o[p * 8 + b] <= od_reg[p][b] ? 1'b0 : data_reg[p][b];
          pin_oe_o[p * 8 + b] <= dir_reg[p][b] & ~(od_reg[p][b] & data_reg[p][b]);
          pin_pullup_o[p * 8 + b] <= pu_reg[p][b];
        end
      end
      high_current_o <= high_current_select & dir_reg[3];
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= '0;
    end else if (sfr_rd_i) begin
      case (kind)
        // Output bits return the latch; input bits return the pin.
        3'd0: sfr_rdata_o <= ((data_reg[idx] & dir_reg[idx])
                             | (pin_digital[idx * 8 +: 8] & ~dir_reg[idx])) & port_mask(idx);
        3'd1: sfr_rdata_o <= dir_reg[idx];
        3'd2: sfr_rdata_o <= pu_reg[idx];
        3'd3: sfr_rdata_o <= od_reg[idx];
        3'd4: sfr_rdata_o <= db_reg[idx];
        3'd5: begin
          case (idx)
            2'd0: sfr_rdata_o <= debounce_time_select;
            2'd1: sfr_rdata_o <= high_current_select;
            2'd2: sfr_rdata_o <= digital_input_select_a;
            default: sfr_rdata_o <= digital_input_select_b;
          endcase
        end
        default: sfr_rdata_o <= '0;
      endcase
    end
  end

  assign sfr_hit_o = (kind != 3'd7);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Samples for which pin 11 has stayed away from its filtered level. It never
  // lags the filter's own count, so a level change while it is short is an
  // early release; it saturates so that a long run cannot wrap to a small value.
  logic [CW-1:0] run_cnt;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !db_reg[1][3] || pin_i[11] == pin_filtered[11]) begin
      run_cnt <= '0;
    end else if (run_cnt != '1) begin
      run_cnt <= run_cnt + CW'(1);
    end
  end

  property rst_values;
    $fell(sys_rst_i) |-> od_reg[0] == `QGPIO_PORT0_OD_RESET && dir_reg[0] == 8'h00;
  endproperty
  reset_value_a: assert property (rst_values) else $error("Bad reset value");
  dir_write_a: assert property (sfr_wr_i && sfr_addr_i == `QGPIO_PORT1_DIRECTION
      |=> dir_reg[1] == $past(sfr_wdata_i)) else $error("Direction write lost");
  push_pull_a: assert property (dir_reg[3][0] && !od_reg[3][0]
      |=> pin_oe_o[24] && pin_o[24] == $past(data_reg[3][0])) else $error("Drive wrong");
  od_high_a: assert property (od_reg[0][1] && data_reg[0][1]
      |=> !pin_oe_o[1]) else $error("Open-drain drove high");
  od_low_a: assert property (od_reg[0][1] && !data_reg[0][1] && dir_reg[0][1]
      |=> pin_oe_o[1] && !pin_o[1]) else $error("Open-drain low missing");
  input_read_a: assert property (sfr_rd_i && sfr_addr_i == `QGPIO_PORT3_DATA
      && !dir_reg[3][5] && !db_reg[3][5] && $stable(pin_i[29])
      |=> sfr_rdata_o[5] == $past(pin_i[29], 2)) else $error("Input read wrong");
  db_hold_a: assert property (db_reg[1][2] && $changed(pin_i[10])
      |=> $stable(pin_filtered[10])) else $error("Debounce passed a glitch");
  dbt_map_a: assert property (debounce_time_select[1:0] == 2'd3
      |-> dbt_cycles == CW'(400)) else $error("Debounce length wrong");
  pu_out_a: assert property (pu_reg[2][4] |=> pin_pullup_o[20])
    else $error("Pull-up lost");
  hc_port3_a: assert property (high_current_o != 8'h00
      |-> (high_current_o & ~$past(dir_reg[3])) == 8'h00)
    else $error("High current on input");
  analog_rd_a: assert property (analog_select_o[7] |-> !pin_digital[8])
    else $error("Analog pin read digital");

  unmapped_rd_a: assert property (sfr_rd_i && !sfr_hit_o
      |=> sfr_rdata_o == 8'h00) else $error("Unmapped read not zero");
  port2_top_a: assert property (pin_oe_o[23:22] == 2'b00
      && pin_pullup_o[23:22] == 2'b00) else $error("Missing port 2 pin driven");
  out_read_a: assert property (sfr_rd_i && sfr_addr_i == `QGPIO_PORT0_DATA
      && dir_reg[0][4] |=> sfr_rdata_o[4] == $past(data_reg[0][4]))
    else $error("Output latch read wrong");
  in_dir_a: assert property (!dir_reg[2][0] |=> !pin_oe_o[16])
    else $error("Input pin driven");
  rst_pins_a: assert property ($fell(sys_rst_i) |-> pin_oe_o == 32'h0
      && pin_pullup_o == 32'h0) else $error("Pins active after reset");
  pu_off_a: assert property (!pu_reg[1][5] |=> !pin_pullup_o[13])
    else $error("Pull-up stuck on");
  od_drive_a: assert property (od_reg[2][3] |=> !pin_o[19])
    else $error("Open-drain drove a one");
  db_off_a: assert property (!db_reg[0][3] |=> pin_filtered[3] == $past(pin_i[3]))
    else $error("Unfiltered pin delayed");
  analog_b_a: assert property (analog_select_o[14] |-> !pin_digital[17])
    else $error("Analog pin read digital");
  hc_set_a: assert property (high_current_select[2] && dir_reg[3][2]
      |=> high_current_o[2]) else $error("High current not applied");
  db_early_a: assert property (db_reg[1][3] && pin_i[11] != pin_filtered[11]
      && run_cnt < dbt_cycles - CW'(1) |=> $stable(pin_filtered[11]))
    else $error("Debounce released early");

  cov_od_c: cover property (od_reg[1][0] && dir_reg[1][0] && data_reg[1][0]);
  cov_db_c: cover property (db_reg[0][0] ##1 $changed(pin_filtered[0]));
  cov_rd_c: cover property (sfr_rd_i && kind == 3'd0);
  cov_an_c: cover property (analog_select_o != 15'h0);
  cov_hc_c: cover property (high_current_o != 8'h00);
endmodule

/* hw/qgpio_cfg.svh */
`ifndef QGPIO_CFG_SVH
`define QGPIO_CFG_SVH
// ----------------------------------------------------------------------------
// Register offsets in the special function register space
// ----------------------------------------------------------------------------
`define QGPIO_PORT0_DATA 8'h80
`define QGPIO_PORT1_DATA 8'h88
`define QGPIO_PORT0_DIRECTION 8'h89
`define QGPIO_PORT2_DATA 8'h90
`define QGPIO_PORT1_DIRECTION 8'h91
`define QGPIO_PORT3_DATA 8'h98
`define QGPIO_PORT2_DIRECTION 8'h99
`define QGPIO_PORT3_DIRECTION 8'hA1
`define QGPIO_PORT0_OPENDRAIN 8'hB1
`define QGPIO_PORT1_OPENDRAIN 8'hB9
`define QGPIO_PORT2_OPENDRAIN 8'hC1
`define QGPIO_PORT3_OPENDRAIN 8'hC9
`define QGPIO_PORT0_PULLUP 8'hD1
`define QGPIO_PORT1_PULLUP 8'hD9
`define QGPIO_DEBOUNCE_TIME_SELECT 8'hDA
`define QGPIO_HIGH_CURRENT_SELECT 8'hDB
`define QGPIO_DIGITAL_INPUT_SELECT_A 8'hDC
`define QGPIO_DIGITAL_INPUT_SELECT_B 8'hDD
`define QGPIO_PORT2_PULLUP 8'hE1
`define QGPIO_PORT0_DEBOUNCE 8'hE2
`define QGPIO_PORT1_DEBOUNCE 8'hE3
`define QGPIO_PORT2_DEBOUNCE 8'hE4
`define QGPIO_PORT3_DEBOUNCE 8'hE5
`define QGPIO_PORT3_PULLUP 8'hE9
// ----------------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------------
`define QGPIO_RESET_VALUE 8'h00
`define QGPIO_PORT0_OD_RESET 8'h04
`define QGPIO_PORT2_MASK 8'h3F
`define QGPIO_DIGSEL_B_MASK 8'h7F
`define QGPIO_PORT_DBT_LSB 0
`define QGPIO_RESET_DBT_LSB 2
`define QGPIO_DBT_USED_MASK 8'h0F
// ----------------------------------------------------------------------------
// Timing: clock in MHz and debounce times in microseconds
// ----------------------------------------------------------------------------
`define QGPIO_CLK_MHZ 50
`define QGPIO_DBT_1US 1
`define QGPIO_DBT_2US 2
`define QGPIO_DBT_4US 4
`define QGPIO_DBT_8US 8
`define QGPIO_RST_DBT_8US 8
`define QGPIO_RST_DBT_16US 16
`define QGPIO_RST_DBT_32US 32
`define QGPIO_RST_DBT_64US 64
`define QGPIO_DBT_CYC_1 (`QGPIO_DBT_1US * `QGPIO_CLK_MHZ)
`define QGPIO_DBT_CYC_2 (`QGPIO_DBT_2US * `QGPIO_CLK_MHZ)
`define QGPIO_DBT_CYC_4 (`QGPIO_DBT_4US * `QGPIO_CLK_MHZ)
`define QGPIO_DBT_CYC_8 (`QGPIO_DBT_8US * `QGPIO_CLK_MHZ)
`define QGPIO_RST_CYC_8 (`QGPIO_RST_DBT_8US * `QGPIO_CLK_MHZ)
`define QGPIO_RST_CYC_16 (`QGPIO_RST_DBT_16US * `QGPIO_CLK_MHZ)
`define QGPIO_RST_CYC_32 (`QGPIO_RST_DBT_32US * `QGPIO_CLK_MHZ)
`define QGPIO_RST_CYC_64 (`QGPIO_RST_DBT_64US * `QGPIO_CLK_MHZ)
`endif

/* hw/qgpio_pkg.sv */
package qgpio_pkg;
  typedef logic [7:0] qgpio_byte_t;
  typedef logic [11:0] qgpio_count_t;
endpackage

/* hw/qgpio_debounce.sv */
`include "qgpio_cfg.svh"

// Per-pin filter: the filtered level follows the raw level only once the raw
// level has stayed different from it for the selected number of cycles.
module qgpio_debounce
  import qgpio_pkg::*;
#(
  parameter int CW = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic enable_i,
  input wire logic [CW-1:0] limit_i,
  // Data
  input wire logic raw_i,
  output logic level_o
);
  logic [CW-1:0] count;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count <= '0;
      level_o <= 1'b0;
    end else if (!enable_i || raw_i == level_o) begin
      count <= '0;
      if (!enable_i) begin
        level_o <= raw_i;
      end
    end else if (count >= limit_i - CW'(1)) begin
      count <= '0;
      level_o <= raw_i;
    end else begin
      count <= count + CW'(1);
    end
  end
endmodule

/* sim/qgpio_board.sv */
// ----------------------------------------------------------------------------
// Board circuitry on the port pins
// ----------------------------------------------------------------------------
module qgpio_board (
  // Clock
  input wire logic clk_i,
  // Device side of each pin
  input wire logic [31:0] dev_out_i,
  input wire logic [31:0] dev_oe_i,
  input wire logic [31:0] dev_pullup_i,
  // External drivers on the board
  input wire logic [31:0] ext_en_i,
  input wire logic [31:0] ext_val_i,
  // Resolved pin level
  output logic [31:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pin must not look like a steady level, so it toggles every cycle.
  logic [31:0] floating = 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    floating <= ~floating;
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (dev_oe_i[i]) begin
        level_o[i] = dev_out_i[i];
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_val_i[i];
      end else if (dev_pullup_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = floating[i];
      end
    end
  end
endmodule

/* sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst, wr, rd, hit;
  logic [7:0] addr, wdata, rdata, hc, d, v, m;
  logic [31:0] pin_in, pin_out, pin_oe, pin_pu, ext_en, ext_val;
  logic [14:0] an;
  logic [1:0] rdsel;
  logic [11:0] rdcyc;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 94;
  logic [7:0] regs [24] = '{8'h80, 8'h88, 8'h89, 8'h90, 8'h91, 8'h98, 8'h99, 8'hA1, 8'hB1,
    8'hB9, 8'hC1, 8'hC9, 8'hD1, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hE1, 8'hE2, 8'hE3,
    8'hE4, 8'hE5, 8'hE9};
  logic [7:0] dir_a [4] = '{8'h89, 8'h91, 8'h99, 8'hA1};
  logic [7:0] dat_a [4] = '{8'h80, 8'h88, 8'h90, 8'h98};
  logic [7:0] od_a [4] = '{8'hB1, 8'hB9, 8'hC1, 8'hC9};
  logic [7:0] pu_a [4] = '{8'hD1, 8'hD9, 8'hE1, 8'hE9};

  qgpio_top i_dut (.clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe), .pin_pullup_o(pin_pu),
    .high_current_o(hc), .analog_select_o(an), .reset_debounce_sel_o(rdsel),
    .reset_debounce_cycles_o(rdcyc));

  qgpio_board i_board (.clk_i(clk), .dev_out_i(pin_out), .dev_oe_i(pin_oe),
    .dev_pullup_i(pin_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_in));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'h90, 8'h99, 8'hE1, 8'hC1, 8'hE4: return 8'h3F;
      8'hDD: return 8'h7F;
      8'hDA: return 8'h0F;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] val);
    @(negedge clk);
    addr = a;
    wdata = val;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dat, output logic h);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    dat = rdata;
    h = hit;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Board holds every pin low so that data registers read back zero.
  task automatic reset_and_check();
    logic h;
    ext_en = 32'hFFFF_FFFF;
    ext_val = 32'h0000_0000;
    rst = 1'b1;
    wait_cyc(12);
    rst = 1'b0;
    chk(pin_oe, 32'h0);
    chk(pin_pu, 32'h0);
    wait_cyc(4);
    foreach (regs[i]) begin
      rd_reg(regs[i], d, h);
      chk(d, (regs[i] == 8'hB1) ? 8'h04 : 8'h00);
      chk(h, 1'b1);
    end
  endtask

  // --------------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end

  initial begin
    logic h;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    reset_and_check();
    rd_reg(8'h81, d, h);
    chk({h, d}, 9'h000);
    foreach (regs[i]) begin
      if (regs[i][2:0] != 3'h0) begin
        v = 8'($random(seed));
        wr_reg(regs[i], v);
        rd_reg(regs[i], d, h);
        chk(d, v & mask_of(regs[i]));
        wr_reg(regs[i], 8'h00);
      end
    end
    for (int p = 0; p < 4; p++) begin
      m = (p == 2) ? 8'h3F : 8'hFF;
      v = 8'($random(seed));
      ext_en = 32'h0;
      wr_reg(dir_a[p], m);
      wr_reg(dat_a[p], v);
      wait_cyc(2);
      chk(pin_out[8*p+:8] & m, v & m);
      chk(pin_oe[8*p+:8], m);
      rd_reg(dat_a[p], d, h);
      chk(d & m, v & m);
      wr_reg(od_a[p], 8'hFF);
      wait_cyc(2);
      chk(pin_oe[8*p+:8], ~v & m);
      chk(pin_out[8*p+:8] & m, 8'h00);
      wr_reg(od_a[p], 8'h00);
      wr_reg(dir_a[p], 8'h00);
      wr_reg(pu_a[p], m);
      wait_cyc(4);
      chk(pin_pu[8*p+:8], m);
      rd_reg(dat_a[p], d, h);
      chk(d & m, m);
      wr_reg(pu_a[p], 8'h00);
      ext_en = 32'hFFFF_FFFF;
      ext_val = $random(seed);
      wait_cyc(4);
      rd_reg(dat_a[p], d, h);
      chk(d & m, ext_val[8*p+:8] & m);
    end
    // A pulse shorter than the window must never reach the filtered level.
    ext_val[11] = 1'b0;
    wr_reg(8'hE3, 8'h08);
    wait_cyc(12);
    for (int c = 0; c < 4; c++) begin
      int n;
      n = 50 << c;
      wr_reg(8'hDA, {4'h0, c[1:0], c[1:0]});
      chk(rdsel, c[1:0]);
      chk(rdcyc, (8 * 50) << c);
      ext_val[11] = ~ext_val[11];
      wait_cyc(n / 2);
      ext_val[11] = ~ext_val[11];
      wait_cyc(4);
      ext_val[11] = ~ext_val[11];
      wait_cyc(n - 8);
      rd_reg(8'h88, d, h);
      chk(d[3], !ext_val[11]);
      wait_cyc(12);
      rd_reg(8'h88, d, h);
      chk(d[3], ext_val[11]);
    end
    wr_reg(8'hE3, 8'h00);
    v = 8'($random(seed));
    m = 8'($random(seed));
    wr_reg(8'hA1, v);
    wr_reg(8'hDB, m);
    wait_cyc(2);
    chk(hc, v & m);
    wr_reg(8'hDB, 8'h00);
    wr_reg(8'hA1, 8'h00);
    ext_val = 32'hFFFF_FFFF;
    v = 8'($random(seed));
    m = 8'($random(seed));
    wr_reg(8'hDC, v);
    wr_reg(8'hDD, m);
    wait_cyc(4);
    chk(an, {m[6:0], v});
    rd_reg(8'h80, d, h);
    chk(d, 8'(~{v[6:2], 1'b0, v[1:0]}));
    rd_reg(8'h88, d, h);
    chk(d, 8'(~{m[4:0], 2'b00, v[7]}));
    wr_reg(8'hB9, 8'h5A);
    reset_and_check();
    finish_test();
  end
endmodule
